// file: design/pmch_handler.sv
// Mapping-parameter access handler: holds PDO mapping tables and answers
// reads and writes with abort codes. Assumes requests, node state and
// channel counts come from logic on the same clock.
`timescale 1ns/1ps
// Function
// - Each PDO holds up to 64 mapping entries at sub-indices 1 to 64.
// - Mapping writes outside Pre-Operational are refused with the state abort.
// - Entry writes are refused with the state abort unless count is zero.
// - An entry naming an unmappable object is refused with the map abort.
// - A count whose objects exceed the PDO length is refused.
// - Any access to sub-index above 64 gets the no-sub-index abort.
// - Dummy, serial receive, encoder control and outputs map only to receive.
// - Error register, inputs, status and position objects map only to transmit.
// - Extra bit-wise digital objects exist above 128 and 256 channels.
// - On request, when idle and no access is offered, the mapping is handed to non-volatile storage.
module pmch_handler (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic node_preop,
  input wire logic [9:0] dig_in_chans,
  input wire logic [9:0] dig_out_chans,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_tx,
  input wire logic [4:0] req_pdo,
  input wire logic [7:0] req_sub,
  input wire logic [31:0] req_data,
  input wire logic store_req,
  output logic busy,
  output logic rsp_valid,
  output logic [31:0] rsp_abort,
  output logic [31:0] rsp_data,
  output logic store_start
);
  import pmch_pkg::*;

  localparam int TBL = 2 * NUM_PDOS;
  localparam int WORDS = TBL * MAX_ENTRIES;

  logic [31:0] map_mem [WORDS];
  logic [WORDS-1:0] ent_set;
  logic [6:0] count_tbl [TBL];
  pmch_state_e state;
  pmch_state_e next_state;
  logic [5:0] sel;
  logic [5:0] next_sel;
  logic [6:0] idx;
  logic [6:0] next_idx;
  logic [6:0] pend;
  logic [6:0] next_pend;
  logic [14:0] sum;
  logic [14:0] next_sum;
  logic next_busy;
  logic next_rsp_valid;
  logic [31:0] next_rsp_abort;
  logic [31:0] next_rsp_data;
  logic next_store_start;
  logic mem_we;
  logic cnt_we;
  logic [6:0] cnt_wdata;
  logic [5:0] cnt_addr;
  logic [11:0] wr_addr;
  logic [11:0] rd_addr;
  logic [11:0] walk_addr;
  logic [14:0] walk_len;
  logic [5:0] req_tbl;
  logic [6:0] cur_count;
  logic accept;
  logic mappable;

  assign req_tbl = {req_tx, req_pdo};
  assign cur_count = count_tbl[req_tbl];
  assign accept = clk_en && req_valid && state == ST_IDLE;
  assign wr_addr = {req_tbl, 6'(req_sub - 8'h01)};
  assign rd_addr = wr_addr;
  assign walk_addr = {sel, 6'(idx - 7'h01)};
  // Entries never written since reset count as zero length.
  assign walk_len = ent_set[walk_addr] ?
    15'(map_mem[walk_addr][ENT_LEN_LSB +: 8]) : 15'h0000;

  pmch_obj_check u_obj_check (
    .obj_index(req_data[ENT_IDX_LSB +: 16]),
    .tx_dir(req_tx),
    .dig_in_chans(dig_in_chans),
    .dig_out_chans(dig_out_chans),
    .mappable(mappable)
  );

  always_comb begin
    next_state = state;
    next_sel = sel;
    next_idx = idx;
    next_pend = pend;
    next_sum = sum;
    next_rsp_valid = 1'b0;
    next_rsp_abort = rsp_abort;
    next_rsp_data = rsp_data;
    next_store_start = 1'b0;
    mem_we = 1'b0;
    cnt_we = 1'b0;
    cnt_wdata = COUNT_RESET;
    cnt_addr = req_tbl;
    unique case (state)
      ST_IDLE: begin
        // Storing is held off while a request is offered or a count is being checked.
        next_store_start = clk_en && store_req && !req_valid;
        if (accept) begin
          next_rsp_valid = 1'b1;
          next_rsp_abort = ABORT_NONE;
          next_rsp_data = 32'h0000_0000;
          if (req_sub > SUB_LAST) begin
            next_rsp_abort = ABORT_NOSUB;
          end else if (!req_write) begin
            if (req_sub == SUB_COUNT) begin
              next_rsp_data = {25'h0000000, cur_count};
            end else if (ent_set[rd_addr]) begin
              next_rsp_data = map_mem[rd_addr];
            end
          end else if (!node_preop) begin
            next_rsp_abort = ABORT_STATE;
          end else if (req_sub == SUB_COUNT) begin
            if (req_data == 32'h0000_0000) begin
              cnt_we = 1'b1;
            end else if (req_data > 32'(COUNT_MAX)) begin
              next_rsp_abort = ABORT_LEN;
            end else begin
              next_rsp_valid = 1'b0;
              next_state = ST_SUM;
              next_sel = req_tbl;
              next_idx = 7'h01;
              next_pend = req_data[6:0];
              next_sum = 15'h0000;
            end
          end else if (cur_count != COUNT_RESET) begin
            next_rsp_abort = ABORT_STATE;
          end else if (!mappable) begin
            next_rsp_abort = ABORT_NOMAP;
          end else begin
            mem_we = 1'b1;
          end
        end
      end
      ST_SUM: begin
        next_sum = sum + walk_len;
        next_idx = idx + 7'h01;
        if (idx == pend) begin
          next_state = ST_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp_data = 32'h0000_0000;
          if (sum + walk_len > LEN_LIMIT) begin
            next_rsp_abort = ABORT_LEN;
          end else begin
            next_rsp_abort = ABORT_NONE;
            cnt_we = 1'b1;
            cnt_addr = sel;
            cnt_wdata = pend;
          end
        end
      end
    endcase
    next_busy = next_state == ST_SUM;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      sel <= 6'h00;
      idx <= 7'h00;
      pend <= 7'h00;
      sum <= 15'h0000;
      busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_abort <= ABORT_NONE;
      rsp_data <= 32'h0000_0000;
      store_start <= 1'b0;
      ent_set <= '0;
      for (int i = 0; i < TBL; i++) begin
        count_tbl[i] <= COUNT_RESET;
      end
    end else if (clk_en) begin
      state <= next_state;
      sel <= next_sel;
      idx <= next_idx;
      pend <= next_pend;
      sum <= next_sum;
      busy <= next_busy;
      rsp_valid <= next_rsp_valid;
      rsp_abort <= next_rsp_abort;
      rsp_data <= next_rsp_data;
      store_start <= next_store_start;
      if (mem_we) begin
        ent_set[wr_addr] <= 1'b1;
      end
      if (cnt_we) begin
        count_tbl[cnt_addr] <= cnt_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      map_mem[wr_addr] <= req_data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic acc_wr_entry;
  assign acc_wr_entry = accept && req_write && node_preop &&
    req_sub != SUB_COUNT && req_sub <= SUB_LAST;

  a_sub_range: assert property (
    accept && req_sub > SUB_LAST |=> rsp_valid && rsp_abort == ABORT_NOSUB)
    else $error("sub-index above range not aborted");
  a_state_guard: assert property (
    accept && req_write && !node_preop && req_sub <= SUB_LAST
    |=> rsp_valid && rsp_abort == ABORT_STATE)
    else $error("write outside pre-operational not refused");
  a_entry_order: assert property (
    acc_wr_entry && cur_count != COUNT_RESET
    |=> rsp_valid && rsp_abort == ABORT_STATE)
    else $error("entry write with nonzero count accepted");
  a_unmappable_obj: assert property (
    acc_wr_entry && cur_count == COUNT_RESET && !mappable
    |=> rsp_abort == ABORT_NOMAP)
    else $error("unmappable object not refused");
  a_rx_only_obj: assert property (
    acc_wr_entry && cur_count == COUNT_RESET && req_tx &&
    req_data[31:16] == OBJ_DOUT8 |=> rsp_abort == ABORT_NOMAP)
    else $error("receive-only object mapped for transmit");
  a_tx_only_obj: assert property (
    acc_wr_entry && cur_count == COUNT_RESET && !req_tx &&
    req_data[31:16] == OBJ_DIN8 |=> rsp_abort == ABORT_NOMAP)
    else $error("transmit-only object mapped for receive");
  a_ext_object: assert property (
    acc_wr_entry && cur_count == COUNT_RESET && req_tx &&
    req_data[31:16] == OBJ_DIN_BIT + OBJ_EXT2_OFS &&
    dig_in_chans <= CHAN_EXT2 |=> rsp_abort == ABORT_NOMAP)
    else $error("absent extension object accepted");
  a_count_limit: assert property (
    accept && req_write && node_preop && req_sub == SUB_COUNT &&
    req_data > 32'(COUNT_MAX) |=> rsp_valid && rsp_abort == ABORT_LEN)
    else $error("oversize count not refused");
  a_count_bound: assert property (
    state == ST_IDLE |-> cur_count <= COUNT_MAX)
    else $error("entry count above table size");
  a_walk_ends: assert property (
    $rose(busy) && clk_en |-> ##[1:64] !busy && rsp_valid)
    else $error("count check does not finish");
  a_store_pulse: assert property (
    clk_en && state == ST_IDLE && store_req && !req_valid |=> store_start)
    else $error("store request not forwarded");

  c_entry_ok: cover property (acc_wr_entry ##1 rsp_abort == ABORT_NONE);
  c_count_ok: cover property (busy ##1 !busy && rsp_abort == ABORT_NONE);
  c_len_abort: cover property (busy ##1 rsp_valid && rsp_abort == ABORT_LEN);
  c_store: cover property (store_start);
endmodule

// file: design/pmch_obj_check.sv
// Decides whether an object index may be mapped into a PDO of a direction.
// Assumes channel counts are stable levels from logic on the same clock.
`timescale 1ns/1ps
module pmch_obj_check (
  input wire logic [15:0] obj_index,
  input wire logic tx_dir,
  input wire logic [9:0] dig_in_chans,
  input wire logic [9:0] dig_out_chans,
  output logic mappable
);
  import pmch_pkg::*;

  logic rx_ok;
  logic tx_ok;

  always_comb begin
    rx_ok = 1'b0;
    tx_ok = 1'b0;
    if (obj_index >= OBJ_DUMMY_FIRST && obj_index <= OBJ_DUMMY_LAST) begin
      rx_ok = 1'b1;
    end
    unique case (obj_index)
      OBJ_SER_RX, OBJ_ENC_CTRL, OBJ_DOUT8, OBJ_DOUT_BIT, OBJ_DOUT16,
      OBJ_DOUT32, OBJ_AOUT16: begin
        rx_ok = 1'b1;
      end
      OBJ_ERR_REG, OBJ_AIN_RANGE, OBJ_SER_TX, OBJ_ENC_STAT, OBJ_ENC_FLAGS,
      OBJ_SSI_STAT, OBJ_SSI_OPT, OBJ_DIN8, OBJ_DIN_BIT, OBJ_DIN16,
      OBJ_DIN32, OBJ_AIN16, OBJ_POSITION, OBJ_CAM_STATE,
      OBJ_AREA_STATE: begin
        tx_ok = 1'b1;
      end
      OBJ_DIN_BIT + OBJ_EXT1_OFS: begin
        tx_ok = dig_in_chans > CHAN_EXT1;
      end
      OBJ_DIN_BIT + OBJ_EXT2_OFS: begin
        tx_ok = dig_in_chans > CHAN_EXT2;
      end
      OBJ_DOUT_BIT + OBJ_EXT1_OFS: begin
        rx_ok = dig_out_chans > CHAN_EXT1;
      end
      OBJ_DOUT_BIT + OBJ_EXT2_OFS: begin
        rx_ok = dig_out_chans > CHAN_EXT2;
      end
      default: begin
      end
    endcase
    mappable = tx_dir ? tx_ok : rx_ok;
  end
endmodule

// file: design/pmch_pkg.sv
// Constants and types shared by the mapping configuration handler.
// Assumes one clock domain and a synchronous active-high reset.
package pmch_pkg;
  localparam int MAX_ENTRIES = 64;
  localparam int PDO_BITS = 64;
  localparam int NUM_PDOS = 32;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_LAST = 8'h40;
  localparam logic [6:0] COUNT_MAX = 7'h40;
  localparam logic [6:0] COUNT_RESET = 7'h00;
  localparam logic [14:0] LEN_LIMIT = 15'h0040;
  localparam logic [9:0] CHAN_EXT1 = 10'h080;
  localparam logic [9:0] CHAN_EXT2 = 10'h100;
  localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
  localparam logic [31:0] ABORT_NOMAP = 32'h0604_0041;
  localparam logic [31:0] ABORT_LEN = 32'h0604_0042;
  localparam logic [31:0] ABORT_NOSUB = 32'h0609_0011;
  localparam logic [31:0] ABORT_STATE = 32'h0080_0022;
  localparam int ENT_IDX_LSB = 16;
  localparam int ENT_SUB_LSB = 8;
  localparam int ENT_LEN_LSB = 0;
  localparam logic [15:0] OBJ_DUMMY_FIRST = 16'h0001;
  localparam logic [15:0] OBJ_DUMMY_LAST = 16'h0007;
  localparam logic [15:0] OBJ_ERR_REG = 16'h1001;
  localparam logic [15:0] OBJ_AIN_RANGE = 16'h5420;
  localparam logic [15:0] OBJ_SER_RX = 16'h5601;
  localparam logic [15:0] OBJ_SER_TX = 16'h5602;
  localparam logic [15:0] OBJ_ENC_STAT = 16'h5802;
  localparam logic [15:0] OBJ_ENC_FLAGS = 16'h5803;
  localparam logic [15:0] OBJ_SSI_STAT = 16'h5805;
  localparam logic [15:0] OBJ_SSI_OPT = 16'h5806;
  localparam logic [15:0] OBJ_ENC_CTRL = 16'h5808;
  localparam logic [15:0] OBJ_DIN8 = 16'h6000;
  localparam logic [15:0] OBJ_DIN_BIT = 16'h6020;
  localparam logic [15:0] OBJ_DIN16 = 16'h6100;
  localparam logic [15:0] OBJ_DIN32 = 16'h6120;
  localparam logic [15:0] OBJ_DOUT8 = 16'h6200;
  localparam logic [15:0] OBJ_DOUT_BIT = 16'h6220;
  localparam logic [15:0] OBJ_DOUT16 = 16'h6300;
  localparam logic [15:0] OBJ_DOUT32 = 16'h6320;
  localparam logic [15:0] OBJ_AIN16 = 16'h6401;
  localparam logic [15:0] OBJ_AOUT16 = 16'h6411;
  localparam logic [15:0] OBJ_POSITION = 16'h6820;
  localparam logic [15:0] OBJ_CAM_STATE = 16'h6B00;
  localparam logic [15:0] OBJ_AREA_STATE = 16'h6C00;
  localparam logic [15:0] OBJ_EXT1_OFS = 16'h0001;
  localparam logic [15:0] OBJ_EXT2_OFS = 16'h0002;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SUM = 2'b10
  } pmch_state_e;
endpackage

// file: sim/pmch_master.sv
// Master model: issues one mapping access at a time and waits for the answer.
// Assumes a handler that answers every taken request with one rsp_valid pulse.
`timescale 1ns/1ps
module pmch_master (
  input wire logic clk,
  input wire logic busy,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_abort,
  input wire logic [31:0] rsp_data,
  output logic req_valid,
  output logic req_write,
  output logic req_tx,
  output logic [4:0] req_pdo,
  output logic [7:0] req_sub,
  output logic [31:0] req_data
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_tx = 1'b0;
    req_pdo = 5'h00;
    req_sub = 8'h00;
    req_data = 32'h0000_0000;
  end
  task automatic access(input logic wr, input logic tx, input logic [4:0] pdo,
      input logic [7:0] sub, input logic [31:0] data,
      output logic [31:0] abort, output logic [31:0] rdata, output int lat);
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    req_valid <= 1'b1;
    req_write <= wr;
    req_tx <= tx;
    req_pdo <= pdo;
    req_sub <= sub;
    req_data <= data;
    @(posedge clk);
    // Released sub-index and data lines carry the inverse so stale values cannot pass.
    req_valid <= 1'b0;
    req_sub <= ~sub;
    req_data <= ~data;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    abort = (rsp_valid === 1'b1) ? rsp_abort : 32'hXXXX_XXXX;
    rdata = rsp_data;
    lat = n - 1;
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the mapping configuration handler.
// Assumes the master model drives every request port of the handler.
`timescale 1ns/1ps
module tb_top;
  import pmch_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic node_preop = 1'b0;
  logic [9:0] dig_in_chans = 10'h000;
  logic [9:0] dig_out_chans = 10'h000;
  logic store_req = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid, req_write, req_tx, busy, rsp_valid, store_start;
  logic [4:0] req_pdo;
  logic [4:0] pdo = 5'h00;
  logic [7:0] req_sub;
  logic [31:0] req_data, rsp_abort, rsp_data, ab, rd;
  logic [15:0] rx_obj [9] = '{OBJ_DUMMY_FIRST, OBJ_DUMMY_LAST, OBJ_SER_RX,
    OBJ_ENC_CTRL, OBJ_DOUT8, OBJ_DOUT_BIT, OBJ_DOUT16, OBJ_DOUT32, OBJ_AOUT16};
  logic [15:0] tx_obj [15] = '{OBJ_ERR_REG, OBJ_AIN_RANGE, OBJ_SER_TX,
    OBJ_ENC_STAT, OBJ_ENC_FLAGS, OBJ_SSI_STAT, OBJ_SSI_OPT, OBJ_DIN8,
    OBJ_DIN_BIT, OBJ_DIN16, OBJ_DIN32, OBJ_AIN16, OBJ_POSITION,
    OBJ_CAM_STATE, OBJ_AREA_STATE};
  logic [9:0] chans [4] = '{10'h080, 10'h081, 10'h100, 10'h101};
  int n_mismatch = 0;
  int check_count = 0;
  int lat;
  always #5 clk = ~clk;
  pmch_handler u_pmch_handler (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .node_preop(node_preop), .dig_in_chans(dig_in_chans),
    .dig_out_chans(dig_out_chans), .req_valid(req_valid),
    .req_write(req_write), .req_tx(req_tx), .req_pdo(req_pdo),
    .req_sub(req_sub), .req_data(req_data), .store_req(store_req),
    .busy(busy), .rsp_valid(rsp_valid), .rsp_abort(rsp_abort),
    .rsp_data(rsp_data), .store_start(store_start));
  pmch_master u_pmch_master (.clk(clk), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_abort(rsp_abort), .rsp_data(rsp_data), .req_valid(req_valid),
    .req_write(req_write), .req_tx(req_tx), .req_pdo(req_pdo),
    .req_sub(req_sub), .req_data(req_data));
  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic tx, input logic [7:0] sub,
      input logic [31:0] data, input logic [31:0] exp);
    u_pmch_master.access(wr, tx, pdo, sub, data, ab, rd, lat);
    chk(ab, exp);
  endtask
  task automatic s_state;
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0000, ABORT_STATE);
    acc(1'b1, 1'b0, 8'h01, 32'h6200_0108, ABORT_STATE);
    acc(1'b0, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    node_preop <= 1'b1;
  endtask
  task automatic s_order;
    pdo = 5'h01;
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    acc(1'b1, 1'b1, 8'h01, 32'h6000_0108, ABORT_NONE);
    acc(1'b1, 1'b1, 8'h40, 32'h6100_0110, ABORT_NONE);
    acc(1'b1, 1'b1, 8'h41, 32'h6000_0108, ABORT_NOSUB);
    acc(1'b0, 1'b1, 8'h41, 32'h0000_0000, ABORT_NOSUB);
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0040, ABORT_NONE);
    chk(32'(lat), 32'h0000_0040);
    acc(1'b0, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    chk(rd, 32'h0000_0040);
    acc(1'b0, 1'b1, 8'h40, 32'h0000_0000, ABORT_NONE);
    chk(rd, 32'h6100_0110);
    acc(1'b1, 1'b1, 8'h02, 32'h6000_0108, ABORT_STATE);
  endtask
  task automatic s_len;
    pdo = 5'h02;
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    for (int i = 1; i <= 9; i++) begin
      acc(1'b1, 1'b1, 8'(i), 32'h6000_0108, ABORT_NONE);
    end
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0009, ABORT_LEN);
    acc(1'b0, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    chk(rd, 32'h0000_0000);
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0041, ABORT_LEN);
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0008, ABORT_NONE);
    chk(32'(lat), 32'h0000_0008);
  endtask
  task automatic s_dir;
    pdo = 5'h04;
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    acc(1'b1, 1'b0, 8'h00, 32'h0000_0000, ABORT_NONE);
    foreach (rx_obj[i]) begin
      acc(1'b1, 1'b0, 8'h01, {rx_obj[i], 16'h0108}, ABORT_NONE);
      acc(1'b1, 1'b1, 8'h01, {rx_obj[i], 16'h0108}, ABORT_NOMAP);
    end
    foreach (tx_obj[i]) begin
      acc(1'b1, 1'b1, 8'h01, {tx_obj[i], 16'h0108}, ABORT_NONE);
      acc(1'b1, 1'b0, 8'h01, {tx_obj[i], 16'h0108}, ABORT_NOMAP);
    end
    acc(1'b1, 1'b1, 8'h01, 32'h1000_0020, ABORT_NOMAP);
    acc(1'b1, 1'b0, 8'h01, 32'h0008_0108, ABORT_NOMAP);
  endtask
  task automatic s_ext;
    pdo = 5'h05;
    acc(1'b1, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    acc(1'b1, 1'b0, 8'h00, 32'h0000_0000, ABORT_NONE);
    foreach (chans[i]) begin
      dig_in_chans <= chans[i];
      dig_out_chans <= chans[i];
      acc(1'b1, 1'b1, 8'h01, 32'h6021_0101,
        (chans[i] > CHAN_EXT1) ? ABORT_NONE : ABORT_NOMAP);
      acc(1'b1, 1'b1, 8'h01, 32'h6022_0101,
        (chans[i] > CHAN_EXT2) ? ABORT_NONE : ABORT_NOMAP);
      acc(1'b1, 1'b0, 8'h01, 32'h6221_0101,
        (chans[i] > CHAN_EXT1) ? ABORT_NONE : ABORT_NOMAP);
      acc(1'b1, 1'b0, 8'h01, 32'h6222_0101,
        (chans[i] > CHAN_EXT2) ? ABORT_NONE : ABORT_NOMAP);
    end
  endtask
  task automatic s_store;
    @(posedge clk);
    store_req <= 1'b1;
    @(posedge clk);
    store_req <= 1'b0;
    @(posedge clk);
    chk({31'h0000_0000, store_start}, 32'h0000_0001);
    @(posedge clk);
    chk({31'h0000_0000, store_start}, 32'h0000_0000);
    // A request held while the enable is low starts no store until the enable returns.
    clk_en <= 1'b0;
    store_req <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk({31'h0000_0000, store_start}, 32'h0000_0000);
    clk_en <= 1'b1;
    @(posedge clk);
    store_req <= 1'b0;
    @(posedge clk);
    chk({31'h0000_0000, store_start}, 32'h0000_0001);
  endtask
  task automatic s_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    pdo = 5'h01;
    acc(1'b0, 1'b1, 8'h00, 32'h0000_0000, ABORT_NONE);
    chk(rd, 32'h0000_0000);
    acc(1'b0, 1'b1, 8'h40, 32'h0000_0000, ABORT_NONE);
    chk(rd, 32'h0000_0000);
    acc(1'b1, 1'b1, 8'h01, 32'h6000_0108, ABORT_NONE);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    s_state;
    s_order;
    s_len;
    s_dir;
    s_ext;
    s_store;
    s_reset;
    give_verdict;
  end
endmodule
